/* File: core/vic_arbiter.sv */
// priority arbiter: highest level wins, lowest vector breaks ties
`timescale 1ns/1ps
`default_nettype none
module vic_arbiter #(
    parameter int N = 80,
    parameter int VW = 7
) (
    // requests
    input wire logic [N-1:0] pend_in,
    input wire logic [N-1:0][2:0] prio_in,
    // winner
    output logic valid_out,
    output logic [VW-1:0] vec_out,
    output logic [2:0] prio_out
);
    logic [2:0] best_p;
    logic [VW-1:0] best_v;

    // scan from the top so that >= lets the lower vector win a tie
    always_comb begin
        best_p = 3'h0;
        best_v = '0;
        for (int v = N - 1; v >= 0; v--) begin
            if (pend_in[v] && prio_in[v] >= best_p) begin // see R16
                best_p = prio_in[v];
                best_v = VW'(v);
            end
        end
        valid_out = (best_p != 3'h0);
        vec_out = best_v;
        prio_out = best_p;
    end
endmodule : vic_arbiter
`default_nettype wire

/* File: core/vic_core.sv */
// vectored interrupt controller: flags, enables, priorities, vector output
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vic_core import vic_pkg::*; #(
    parameter int HW = HOLD_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // peripheral events, one bit per vector
    input wire logic [NUM_VEC-1:0] event_in,
    // core side
    input wire logic [2:0] cpu_prio_in,
    input wire logic insn_done_in,
    output logic irq_req_out,
    output logic [VEC_W-1:0] irq_vector_out,
    output logic [2:0] irq_prio_out,
    output logic [23:0] irq_addr_out
);
    // ======================================================================
    // state
    vic_core_st_t q;
    vic_core_st_t d;

    logic [NUM_VEC-1:0] flag_flat;
    logic [NUM_VEC-1:0] en_flat;
    logic [NUM_VEC-1:0] impl_flat;
    logic [NUM_VEC-1:0][2:0] eff_prio;
    logic [NUM_VEC-1:0] pend;
    logic best_valid;
    logic [VEC_W-1:0] best_vec;
    logic [2:0] best_prio;
    logic hold_active;
    logic [HW-1:0] hold_count;
    logic hold_load;

    assign flag_flat = q.flag;
    assign en_flat = q.en;
    assign impl_flat = IMPL_MASK; // see R6 R7 R8
    assign hold_load = wr_in && addr_in == OFS_HOLD;

    // ======================================================================
    // eligibility of each vector
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            // unimplemented vectors never request and read zero priority
            eff_prio[v] = impl_flat[v] ? q.prio[v] : PRIO_OFF; // see R9
            pend[v] = flag_flat[v] && en_flat[v] // see R10 R11
                && eff_prio[v] != PRIO_OFF // see R15
                && (!hold_active || eff_prio[v] == PRIO_MAX); // see R14
        end
    end

    vic_arbiter #(
        .N(NUM_VEC),
        .VW(VEC_W)
    ) u_arb (
        .pend_in(pend),
        .prio_in(eff_prio),
        .valid_out(best_valid),
        .vec_out(best_vec),
        .prio_out(best_prio)
    );

    vic_hold_counter #(
        .W(HW)
    ) u_hold (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(hold_load),
        .load_val_in(wdata_in[HW-1:0]),
        .tick_in(insn_done_in),
        .count_out(hold_count),
        .active_out(hold_active)
    );

    // ======================================================================
    // register writes, reads and vector presentation
    always_comb begin
        logic [15:0] rd_v;
        int pw;
        rd_v = '0;
        pw = 0;
        d = q;
        // flags, enables and priorities are stored per vector number, so the
        // word and bit of every source follow from its vector alone
        for (int w = 0; w < NUM_FWORD; w++) begin
            if (wr_in && addr_in == OFS_FLAG + 8'(w)) begin
                d.flag[w] = wdata_in;
            end
            // an event in the clearing cycle still sets its flag
            d.flag[w] = (d.flag[w] | event_in[w*16 +: 16]) & IMPL_MASK[w]; // see R3 R4 R5
            if (wr_in && addr_in == OFS_EN + 8'(w)) begin
                d.en[w] = wdata_in & IMPL_MASK[w]; // see R11 R12 R13
            end
        end
        if (wr_in && addr_in >= OFS_PRIO && addr_in < OFS_PRIO + 8'(NUM_PWORD)) begin
            pw = int'(addr_in - OFS_PRIO);
            for (int j = 0; j < 4; j++) begin
                d.prio[pw*4 + j] = wdata_in[j*4 +: 3];
            end
        end
        if (wr_in && addr_in == OFS_CTRL) begin
            d.alt = wdata_in[CTRL_ALT_BIT];
        end

        if (addr_in >= OFS_FLAG && addr_in < OFS_FLAG + 8'(NUM_FWORD)) begin
            rd_v = q.flag[3'(addr_in - OFS_FLAG)];
        end else if (addr_in >= OFS_EN && addr_in < OFS_EN + 8'(NUM_FWORD)) begin
            rd_v = q.en[3'(addr_in - OFS_EN)];
        end else if (addr_in >= OFS_PRIO && addr_in < OFS_PRIO + 8'(NUM_PWORD)) begin
            for (int j = 0; j < 4; j++) begin
                rd_v[j*4 +: 3] = eff_prio[int'(addr_in - OFS_PRIO)*4 + j];
            end
        end else if (addr_in == OFS_CTRL) begin
            rd_v[CTRL_ALT_BIT] = q.alt;
        end else if (addr_in == OFS_HOLD) begin
            rd_v[HW-1:0] = hold_count;
        end else if (addr_in == OFS_STAT) begin
            rd_v = {2'b00, hold_active, q.req, q.pri, 2'b00, q.vec};
        end
        // read data stand only in the cycle after the read strobe
        d.rdata = rd_in ? rd_v : 16'h0000;

        // core compares against its own running level
        d.req = best_valid && best_prio > cpu_prio_in; // see R10 R14
        d.vec = best_vec; // see R16
        d.pri = best_prio;
        d.addr = VEC_BASE + {16'h0000, best_vec, 1'b0} // see R1
            + (q.alt ? ALT_OFS : 24'h000000); // see R2
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= CORE_RST; // see R11
        end else begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
    assign irq_req_out = q.req;
    assign irq_vector_out = q.vec;
    assign irq_prio_out = q.pri;
    assign irq_addr_out = q.addr;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // tie-break helper: no lower vector pending at the winning level
    logic tie_ok;
    always_comb begin
        tie_ok = 1'b1;
        for (int v = 0; v < NUM_VEC; v++) begin
            if (VEC_W'(v) < best_vec && pend[v] && eff_prio[v] >= best_prio) begin
                tie_ok = 1'b0;
            end
        end
    end

    property p_addr_map;
        irq_req_out |-> irq_addr_out == VEC_BASE + {16'h0000, irq_vector_out, 1'b0}
            + ($past(q.alt) ? ALT_OFS : 24'h000000);
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("vector address mismatch"); // see R1 R2

    property p_enabled;
        best_valid |-> en_flat[best_vec] && flag_flat[best_vec];
    endproperty
    a_enabled: assert property (p_enabled) else $error("disabled source selected"); // see R10

    property p_unimpl_en;
        rd_in && addr_in == OFS_EN |=> rdata_out[15:14] == 2'b00 && rdata_out[4] == 1'b0;
    endproperty
    a_unimpl_en: assert property (p_unimpl_en) else $error("reserved enable bit read one"); // see R13

    sequence s_en_write;
        wr_in && addr_in == OFS_EN;
    endsequence
    sequence s_en_read;
        rd_in && !wr_in && addr_in == OFS_EN;
    endsequence
    property p_en_rw;
        s_en_write ##1 s_en_read |=> rdata_out == ($past(wdata_in, 2) & IMPL_MASK[0]);
    endproperty
    a_en_rw: assert property (p_en_rw) else $error("enable word0 read back wrong"); // see R11 R12

    property p_prio_zero;
        best_valid |-> eff_prio[best_vec] != PRIO_OFF;
    endproperty
    a_prio_zero: assert property (p_prio_zero) else $error("level zero source selected"); // see R15

    property p_hold;
        hold_active && best_valid |-> best_prio == PRIO_MAX;
    endproperty
    a_hold: assert property (p_hold) else $error("low level taken during hold"); // see R14

    property p_tie;
        best_valid |-> tie_ok;
    endproperty
    a_tie: assert property (p_tie) else $error("higher vector won a tie"); // see R16

    property p_conv_flag;
        event_in[13] |=> flag_flat[13];
    endproperty
    a_conv_flag: assert property (p_conv_flag) else $error("converter flag not set"); // see R3

    property p_vec_range;
        irq_req_out |-> irq_vector_out <= VEC_LAST;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector beyond table"); // see R9

    // read data are a one-cycle answer; the port shows zero otherwise
    property p_rdata_idle;
        !rd_in |=> rdata_out == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

    property p_prio_read;
        rd_in && addr_in >= OFS_PRIO && addr_in < OFS_PRIO + 8'(NUM_PWORD)
            |=> rdata_out[15] == 1'b0 && rdata_out[11] == 1'b0
            && rdata_out[7] == 1'b0 && rdata_out[3] == 1'b0;
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("priority spare bit read one"); // see R15

    property p_no_winner;
        !best_valid |=> !irq_req_out && irq_vector_out == '0 && irq_prio_out == PRIO_OFF;
    endproperty
    a_no_winner: assert property (p_no_winner) else $error("request with nothing pending"); // see R10 R11

    property p_present;
        best_valid |=> irq_vector_out == $past(best_vec) && irq_prio_out == $past(best_prio)
            && irq_req_out == $past(best_prio > cpu_prio_in);
    endproperty
    a_present: assert property (p_present) else $error("winner not presented"); // see R16

    // every implemented event shows in its flag one cycle later
    property p_flag_set;
        (event_in & impl_flat) != '0
            |=> (flag_flat & $past(event_in & impl_flat)) == $past(event_in & impl_flat);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost"); // see R4 R5 R6 R7 R8 R9

    property p_flag_impl;
        (flag_flat & ~impl_flat) == '0 && (en_flat & ~impl_flat) == '0;
    endproperty
    a_flag_impl: assert property (p_flag_impl) else $error("unimplemented bit set"); // see R13

    property p_addr_form;
        irq_addr_out[0] == 1'b0 && irq_addr_out[23:9] == 15'h0000;
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("vector address malformed"); // see R1

    property p_alt_bit;
        1'b1 |=> irq_addr_out[8] == $past(q.alt);
    endproperty
    a_alt_bit: assert property (p_alt_bit) else $error("table select not applied"); // see R2

    property p_ctrl_wr;
        wr_in && addr_in == OFS_CTRL |=> q.alt == $past(wdata_in[CTRL_ALT_BIT]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("table select write lost"); // see R2

    property p_en_bits;
        wr_in && addr_in == OFS_EN |=> en_flat[13] == $past(wdata_in[13])
            && en_flat[10] == $past(wdata_in[10]) && en_flat[9] == $past(wdata_in[9])
            && en_flat[0] == $past(wdata_in[0]);
    endproperty
    a_en_bits: assert property (p_en_bits) else $error("enable word0 bit not stored"); // see R12

    property p_hold_load;
        hold_load |=> hold_count == $past(wdata_in[HW-1:0]);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("hold count not loaded"); // see R14

    property p_hold_keep;
        hold_active && !hold_load && !insn_done_in |=> hold_count == $past(hold_count);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold count moved idle"); // see R14

    // fourth timer at the top level must still pass while a hold runs
    sequence s_top_event;
        event_in[27] && en_flat[27] && eff_prio[27] == PRIO_MAX;
    endsequence

    sequence s_top_kept;
        en_flat[27] && eff_prio[27] == PRIO_MAX && cpu_prio_in != PRIO_MAX;
    endsequence

    property p_top_taken;
        s_top_event ##1 s_top_kept |=> irq_req_out && irq_prio_out == PRIO_MAX;
    endproperty
    a_top_taken: assert property (p_top_taken) else $error("top level source not taken"); // see R14
endmodule : vic_core
`default_nettype wire

/* File: core/vic_hold_counter.sv */
// instruction count that holds off lower priority sources
`timescale 1ns/1ps
`default_nettype none
module vic_hold_counter #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic load_in,
    input wire logic [W-1:0] load_val_in,
    input wire logic tick_in,
    // state
    output logic [W-1:0] count_out,
    output logic active_out
);
    typedef struct packed {
        logic [W-1:0] count;
    } vic_hold_st_t;

    vic_hold_st_t st_q;
    vic_hold_st_t st_d;

    // a reload wins over a retiring instruction in the same cycle
    always_comb begin
        st_d = st_q;
        if (load_in) begin
            st_d.count = load_val_in;
        end else if (tick_in && st_q.count != '0) begin
            st_d.count = st_q.count - W'(1); // see R14
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_out = st_q.count;
    assign active_out = (st_q.count != '0);

    property p_hold_tick;
        @(posedge clk_in) disable iff (!reset_n_in)
        tick_in && !load_in && st_q.count != '0 |=> st_q.count == $past(st_q.count) - W'(1);
    endproperty
    a_hold_tick: assert property (p_hold_tick) else $error("hold count did not step"); // see R14
endmodule : vic_hold_counter
`default_nettype wire

/* File: core/vic_pkg.sv */
// constants, types and register map of the vectored interrupt controller
// ==========================================================================
// What this block does
// R1: each source owns a fixed vector; primary entry is 0x14 plus twice vector.
// R2: alternate table entry sits exactly 0x100 above the primary entry.
// R3: converter done is vector 13, flag word0 bit 13, priority word3 bits 6:4.
// R4: external pins one and two use vectors 20 and 29, flag word1 bits 4, 13.
// R5: change notification is vector 19, flag word1 bit 3, priority word4 14:12.
// R6: serial port one receive, transmit, error use vectors 11, 12 and 65.
// R7: sync port fault is vector 9, transfer done vector 10, flag word0 bits 9, 10.
// R8: five timers use vectors 3, 7, 8, 27, 28; fourth timer flag word1 bit 11.
// R9: vectors reach 77; charge time unit event is 77, flag word4 bit 13.
// R10: a source reaches the core only while its enable bit is one.
// R11: enable zero blocks the source; enable word0 bits read, write, reset to zero.
// R12: enable word0 holds sync done bit 10, fault 9, converter 13, pin zero 0.
// R13: enable word0 bits 15, 14 and 4 read zero and ignore writes.
// R14: while hold count runs, sources below priority 7 are held off.
// R15: priority fields encode levels one to seven; zero disables the source.
// R16: among equal highest priorities the lowest vector number is presented first.
// ==========================================================================
package vic_pkg;

    // ======================================================================
    // sizes
    localparam int NUM_VEC = 80;
    localparam int NUM_FWORD = 5;
    localparam int NUM_PWORD = 20;
    localparam int VEC_W = 7;
    localparam int HOLD_W = 14;
    localparam logic [6:0] VEC_LAST = 7'h4D;

    // ======================================================================
    // register offsets on the plain port (word index)
    localparam logic [7:0] OFS_FLAG = 8'h00;
    localparam logic [7:0] OFS_EN = 8'h08;
    localparam logic [7:0] OFS_PRIO = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h30;
    localparam logic [7:0] OFS_HOLD = 8'h31;
    localparam logic [7:0] OFS_STAT = 8'h32;

    // ======================================================================
    // vector table layout
    localparam logic [23:0] VEC_BASE = 24'h000014;
    localparam logic [23:0] ALT_OFS = 24'h000100;

    // ======================================================================
    // field values and reset values
    localparam logic [2:0] PRIO_RST = 3'h4;
    localparam logic [2:0] PRIO_MAX = 3'h7;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam int CTRL_ALT_BIT = 0;
    localparam logic [NUM_FWORD-1:0][15:0] IMPL_MASK =
        {16'h210E, 16'h4006, 16'h22E3, 16'hFE1F, 16'h3FEF};

    typedef struct packed {
        logic [NUM_FWORD-1:0][15:0] flag;
        logic [NUM_FWORD-1:0][15:0] en;
        logic [NUM_VEC-1:0][2:0] prio;
        logic alt;
        logic [15:0] rdata;
        logic req;
        logic [VEC_W-1:0] vec;
        logic [2:0] pri;
        logic [23:0] addr;
    } vic_core_st_t;

    localparam vic_core_st_t CORE_RST = '{
        flag: '0, en: '0, prio: {NUM_VEC{PRIO_RST}}, alt: 1'b0, rdata: '0,
        req: 1'b0, vec: '0, pri: '0, addr: '0};

endpackage : vic_pkg

/* File: tb/tb_top.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vic_pkg::*;
    // ======================================================================
    // signals
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [NUM_VEC-1:0] event_in = '0;
    logic run = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [15:0] rdata_out;
    logic [2:0] cpu_prio;
    logic insn_done;
    logic irq_req_out;
    logic [VEC_W-1:0] irq_vector_out;
    logic [2:0] irq_prio_out;
    logic [23:0] irq_addr_out;
    int fail_count = 0;
    int checked = 0;
    int seed = 39552;
    int vecs[16] = '{0, 3, 7, 8, 9, 10, 11, 12, 13, 19, 20, 27, 28, 29, 65, 77};

    always #5 clk_in = ~clk_in;

    vic_core #(.HW(HOLD_W)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .event_in(event_in), .cpu_prio_in(cpu_prio),
        .insn_done_in(insn_done), .irq_req_out(irq_req_out),
        .irq_vector_out(irq_vector_out), .irq_prio_out(irq_prio_out),
        .irq_addr_out(irq_addr_out));

    vic_cpu_model u_cpu (.clk_in(clk_in), .reset_n_in(reset_n_in), .run_in(run),
        .lvl_in(lvl), .cpu_prio_out(cpu_prio), .insn_done_out(insn_done));

    // ======================================================================
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask : settle

    // outputs follow two edges after the event edge
    task automatic fire(input int a, input int b);
        logic [NUM_VEC-1:0] ev;
        ev = '0;
        ev[a] = 1'b1;
        ev[b] = 1'b1;
        @(posedge clk_in);
        event_in <= ev;
        @(posedge clk_in);
        event_in <= '0;
        @(posedge clk_in);
        #1;
    endtask : fire

    task automatic arm(input int v, input int p);
        wr(OFS_PRIO + 8'(v / 4), 16'(p << ((v % 4) * 4)));
        wr(OFS_EN + 8'(v / 16), 16'(1 << (v % 16)));
    endtask : arm

    task automatic clr();
        for (int i = 0; i < NUM_FWORD; i++) begin
            wr(OFS_FLAG + 8'(i), 16'h0000);
            wr(OFS_EN + 8'(i), 16'h0000);
        end
    endtask : clr

    task automatic outs(input logic r, input int v, input int p);
        chk(irq_req_out, r);
        chk(irq_vector_out, 24'(v));
        chk(irq_prio_out, 24'(p));
    endtask : outs

    function automatic logic [23:0] exp_addr(input int v, input bit alt);
        return 24'h000014 + 24'(2 * v) + (alt ? 24'h000100 : 24'h000000);
    endfunction : exp_addr

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // ======================================================================
    // scenarios
    initial begin
        logic [15:0] d;
        logic [15:0] w;
        int v;
        int p;
        bit alt;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(OFS_EN, d);
        chk(d, 24'h0);
        wr(OFS_EN, 16'hFFFF);
        rd(OFS_EN, d);
        chk(d, 24'h3FEF);
        // write straight followed by read of the same word
        w = 16'($random(seed));
        @(posedge clk_in);
        addr_in <= OFS_EN;
        wdata_in <= w;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, w & 16'h3FEF);
        // every mapped source, random level and table choice
        foreach (vecs[i]) begin
            v = vecs[i];
            p = 1 + int'($unsigned($random(seed)) % 7);
            alt = 1'($random(seed));
            clr();
            wr(OFS_CTRL, {15'h0000, alt});
            arm(v, p);
            fire(v, v);
            outs(1'b1, v, p);
            chk(irq_addr_out, exp_addr(v, alt));
            rd(OFS_FLAG + 8'(v / 16), d);
            chk(d, 24'(1 << (v % 16)));
        end
        // equal levels, then a higher level, then the core's own level
        clr();
        arm(3, 6);
        arm(27, 6);
        fire(3, 27);
        outs(1'b1, 3, 6);
        arm(27, 7);
        settle();
        outs(1'b1, 27, 7);
        @(posedge clk_in);
        lvl <= 3'h7;
        settle();
        chk(irq_req_out, 1'b0);
        lvl <= 3'h0;
        // enable and priority gating of a flagged source
        clr();
        wr(OFS_PRIO + 8'h03, 16'hFFFF);
        rd(OFS_PRIO + 8'h03, d);
        chk(d, 24'h0077);
        wr(OFS_PRIO + 8'h03, 16'h0050);
        fire(13, 13);
        chk(irq_req_out, 1'b0);
        rd(OFS_FLAG, d);
        chk(d, 24'h2000);
        wr(OFS_EN, 16'h2000);
        settle();
        outs(1'b1, 13, 5);
        wr(OFS_PRIO + 8'h03, 16'h0000);
        settle();
        chk(irq_req_out, 1'b0);
        // timed hold: level 7 still passes, others wait for the count
        wr(OFS_PRIO + 8'h03, 16'h0050);
        wr(OFS_HOLD, 16'd6);
        settle();
        chk(irq_req_out, 1'b0);
        arm(27, 7);
        fire(27, 27);
        outs(1'b1, 27, 7);
        rd(OFS_STAT, d);
        chk(d, 24'h3E1B);
        rd(OFS_HOLD, d);
        chk(d, 24'h0006);
        wr(OFS_FLAG + 8'h01, 16'h0000);
        settle();
        chk(irq_req_out, 1'b0);
        run <= 1'b1;
        repeat (8) @(posedge clk_in);
        run <= 1'b0;
        settle();
        outs(1'b1, 13, 5);
        conclude();
    end

    // a hang is cut short well after the expected run time
    initial begin
        #200000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : tb_top
`default_nettype wire

/* File: tb/vic_cpu_model.sv */
// behavioural processor core beside the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // bench control
    input wire logic run_in,
    input wire logic [2:0] lvl_in,
    // controller side
    output logic [2:0] cpu_prio_out,
    output logic insn_done_out
);
    // ======================================================================
    // retire one instruction per cycle while running
    // no acknowledge: software clears flags, so the core only paces the count
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cpu_prio_out <= 3'h0;
            insn_done_out <= 1'b0;
        end else begin
            cpu_prio_out <= lvl_in;
            insn_done_out <= run_in;
        end
    end
endmodule : vic_cpu_model
`default_nettype wire
